/* hdl/cabo_core.sv */
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] invert work register, update zero, keep carry, half carry, overflow
// [RULE2] invert memory byte in place, update zero only
// [RULE3] negate work register, update zero, keep other flags
// [RULE4] negate memory byte in place, update zero only
// [RULE5] clear one bit of a port register, others and flags kept
// [RULE6] raise one bit of a port register, others and flags kept
// [RULE7] swap port bit with carry, only carry changes among flags
// [RULE8] output bit: old carry is driven onto that port bit
// [RULE9] input bit: sampled pin level goes into carry
// [RULE10] clear one bit of a memory byte, no flag changes
// [RULE11] raise one bit of a memory byte, no flag changes
// [RULE12] direction bit one makes the pin output, zero makes it input
// [RULE13] rotate right through carry puts carry into bit 7
// [RULE14] three bit index selects bit 0 to 7
// [RULE15] negate is inverse plus one, eight bits, zero gives zero
module cabo_core (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port a pins
  input wire logic [7:0] portAIn,
  output logic [7:0] portAData,
  output logic [7:0] portAOe,
  // port b pins
  input wire logic [7:0] portBIn,
  output logic [7:0] portBData,
  output logic [7:0] portBOe
);

  // architectural state
  logic [7:0] workRegister;
  cabo_pkg::cabo_flags_t flags;
  cabo_pkg::cabo_cmd_t lastCmd;
  logic [7:0] dataMem [cabo_pkg::CABO_MEM_DEPTH];

  // filtered pin levels
  logic [7:0] portAPin;
  logic [7:0] portBPin;

  // both ports run through the same three-stage filter
  cabo_pin_sync uSyncA (
    .clock(clock),
    .rst(rst),
    .pinIn(portAIn),
    .pinLevel(portAPin)
  );

  cabo_pin_sync uSyncB (
    .clock(clock),
    .rst(rst),
    .pinIn(portBIn),
    .pinLevel(portBPin)
  );

  // apb phases: one wait state, so pready and prdata come from flops
  wire accessPhase = psel & penable;
  wire accessDone = accessPhase & pready;
  wire takeRead = accessPhase & ~pready;

  // address decode
  wire hitCmd = (paddr == cabo_pkg::CABO_CMD_OFS);
  wire hitWork = (paddr == cabo_pkg::CABO_WORK_OFS);
  wire hitFlags = (paddr == cabo_pkg::CABO_FLAGS_OFS);
  wire hitPaData = (paddr == cabo_pkg::CABO_PA_DATA_OFS);
  wire hitPaDir = (paddr == cabo_pkg::CABO_PA_DIR_OFS);
  wire hitPbData = (paddr == cabo_pkg::CABO_PB_DATA_OFS);
  wire hitPbDir = (paddr == cabo_pkg::CABO_PB_DIR_OFS);
  wire hitPaPin = (paddr == cabo_pkg::CABO_PA_PIN_OFS);
  wire hitPbPin = (paddr == cabo_pkg::CABO_PB_PIN_OFS);
  wire hitMem = (paddr[cabo_pkg::CABO_MEM_WIN_MSB:
                       cabo_pkg::CABO_MEM_WIN_LSB] == cabo_pkg::CABO_MEM_WIN)
                && (paddr[1:0] == 2'h0);
  wire [3:0] memIdx = paddr[cabo_pkg::CABO_MEM_IDX_MSB:
                            cabo_pkg::CABO_MEM_IDX_LSB];
  wire hitWritable = hitCmd | hitWork | hitFlags | hitPaData | hitPaDir |
                     hitPbData | hitPbDir | hitMem;
  wire hitAny = hitWritable | hitPaPin | hitPbPin;
  // pin registers are read only, so writing them is an error too
  wire badAccess = pwrite ? ~hitWritable : ~hitAny;

  // write strobes fire only at the edge that completes the transfer
  wire writeOk = accessDone & pwrite & ~badAccess;
  wire wrCmd = writeOk & hitCmd;
  wire wrWork = writeOk & hitWork;
  wire wrFlags = writeOk & hitFlags;
  wire wrPaData = writeOk & hitPaData;
  wire wrPaDir = writeOk & hitPaDir;
  wire wrPbData = writeOk & hitPbData;
  wire wrPbDir = writeOk & hitPbDir;
  wire wrMem = writeOk & hitMem;

  // read mux, narrow registers sit in the low bits
  wire [31:0] readValue =
    hitCmd ? {20'h00000, lastCmd} :
    hitWork ? {24'h000000, workRegister} :
    hitFlags ? {28'h0000000, flags} :
    hitPaData ? {24'h000000, portAData} :
    hitPaDir ? {24'h000000, portAOe} :
    hitPbData ? {24'h000000, portBData} :
    hitPbDir ? {24'h000000, portBOe} :
    hitPaPin ? {24'h000000, portAPin} :
    hitPbPin ? {24'h000000, portBPin} :
    hitMem ? {24'h000000, dataMem[memIdx]} :
    32'h00000000;

  // command fields are taken straight from the write data
  wire cabo_pkg::cabo_cmd_t cmd = pwdata[11:0];
  wire [3:0] cmdOp = cmd.op;
  // [RULE14] bit index select
  wire [7:0] bitMask = cabo_pkg::CABO_ONE << cmd.bitIdx;

  // addressed memory byte and its complements
  wire [7:0] memByte = dataMem[cmd.addr];
  wire [7:0] memInv = ~memByte;
  // [RULE15] inverse plus one
  wire [7:0] memNeg = memInv + cabo_pkg::CABO_ONE;
  wire [7:0] workInv = ~workRegister;
  wire [7:0] workNeg = workInv + cabo_pkg::CABO_ONE;

  // addressed port: latch, direction and filtered pins
  wire ioIsB = (cmd.addr[0] == cabo_pkg::CABO_IO_PORT_B);
  wire [7:0] ioLatch = ioIsB ? portBData : portAData;
  wire [7:0] ioDir = ioIsB ? portBOe : portAOe;
  wire [7:0] ioPin = ioIsB ? portBPin : portAPin;
  wire ioBitOut = |(ioDir & bitMask);
  wire ioBitLatch = |(ioLatch & bitMask);
  wire ioBitPin = |(ioPin & bitMask);
  // the carry mask picks the old carry for the selected bit only
  wire [7:0] carryMask = flags.carryFlag ? bitMask : 8'h00;

  // execution results
  logic [7:0] next_work;
  logic [7:0] next_io;
  logic [7:0] next_mem;
  logic workUpd;
  logic ioUpd;
  logic memUpd;
  cabo_pkg::cabo_flags_t next_flags;

  // one-cycle execute unit, flags start from their held value
  always_comb begin
    next_work = workRegister;
    next_io = ioLatch;
    next_mem = memByte;
    workUpd = 1'b0;
    ioUpd = 1'b0;
    memUpd = 1'b0;
    next_flags = flags;
    case (cmdOp)
      // [RULE1] invert work register
      cabo_pkg::CABO_OP_INVERT_WORK: begin
        next_work = workInv;
        workUpd = 1'b1;
        next_flags.zeroFlag = (workInv == 8'h00);
      end
      // [RULE2] invert memory byte
      cabo_pkg::CABO_OP_INVERT_MEM: begin
        next_mem = memInv;
        memUpd = 1'b1;
        next_flags.zeroFlag = (memInv == 8'h00);
      end
      // [RULE3] negate work register
      cabo_pkg::CABO_OP_NEGATE_WORK: begin
        next_work = workNeg;
        workUpd = 1'b1;
        next_flags.zeroFlag = (workNeg == 8'h00);
      end
      // [RULE4] negate memory byte
      cabo_pkg::CABO_OP_NEGATE_MEM: begin
        next_mem = memNeg;
        memUpd = 1'b1;
        next_flags.zeroFlag = (memNeg == 8'h00);
      end
      // [RULE5] clear port bit
      cabo_pkg::CABO_OP_CLEAR_BIT_OP_IO: begin
        next_io = ioLatch & ~bitMask;
        ioUpd = 1'b1;
      end
      // [RULE6] raise port bit
      cabo_pkg::CABO_OP_RAISE_BIT_OP_IO: begin
        next_io = ioLatch | bitMask;
        ioUpd = 1'b1;
      end
      // [RULE7] swap with carry
      cabo_pkg::CABO_OP_SWAP_CARRY_IO: begin
        // [RULE8] old carry onto port bit
        next_io = (ioLatch & ~bitMask) | carryMask;
        ioUpd = 1'b1;
        // [RULE9] pin level into carry
        next_flags.carryFlag = ioBitOut ? ioBitLatch : ioBitPin;
      end
      // [RULE10] clear memory bit
      cabo_pkg::CABO_OP_CLEAR_BIT_OP_MEM: begin
        next_mem = memByte & ~bitMask;
        memUpd = 1'b1;
      end
      // [RULE11] raise memory bit
      cabo_pkg::CABO_OP_RAISE_BIT_OP_MEM: begin
        next_mem = memByte | bitMask;
        memUpd = 1'b1;
      end
      // [RULE13] carry into bit 7
      cabo_pkg::CABO_OP_ROTATE_RIGHT_CARRY: begin
        next_work = {flags.carryFlag, workRegister[7:1]};
        workUpd = 1'b1;
        next_flags.carryFlag = workRegister[0];
      end
      // unused codes execute as no operation
      default: begin
        next_work = workRegister;
      end
    endcase
  end

  // gated update strobes for each target
  wire doWork = wrCmd & workUpd;
  wire doMem = wrCmd & memUpd;
  wire doPortA = wrCmd & ioUpd & ~ioIsB;
  wire doPortB = wrCmd & ioUpd & ioIsB;

  // apb handshake and read data
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= takeRead;
      pslverr <= takeRead & badAccess;
      prdata <= (takeRead & ~pwrite & ~badAccess) ? readValue : 32'h00000000;
    end
  end

  // last command, kept for readback
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lastCmd <= 12'h000;
    end else if (wrCmd) begin
      lastCmd <= cmd;
    end
  end

  // work register: software write or instruction result
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      workRegister <= cabo_pkg::CABO_BYTE_RST;
    end else if (wrWork) begin
      workRegister <= pwdata[7:0];
    end else if (doWork) begin
      workRegister <= next_work;
    end
  end

  // flags: software write or instruction result
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags <= cabo_pkg::CABO_FLAGS_RST;
    end else if (wrFlags) begin
      flags <= pwdata[3:0];
    end else if (wrCmd) begin
      flags <= next_flags;
    end
  end

  // port a latch; its flops drive the pins directly
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      portAData <= cabo_pkg::CABO_BYTE_RST;
    end else if (wrPaData) begin
      portAData <= pwdata[7:0];
    end else if (doPortA) begin
      portAData <= next_io;
    end
  end

  // port b latch
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      portBData <= cabo_pkg::CABO_BYTE_RST;
    end else if (wrPbData) begin
      portBData <= pwdata[7:0];
    end else if (doPortB) begin
      portBData <= next_io;
    end
  end

  // [RULE12] direction one means output
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      portAOe <= cabo_pkg::CABO_DIR_RST;
      portBOe <= cabo_pkg::CABO_DIR_RST;
    end else begin
      if (wrPaDir) begin
        portAOe <= pwdata[7:0];
      end
      if (wrPbDir) begin
        portBOe <= pwdata[7:0];
      end
    end
  end

  // data memory; bus and command writes never fall in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < cabo_pkg::CABO_MEM_DEPTH; i++) begin
        dataMem[i] <= cabo_pkg::CABO_BYTE_RST;
      end
    end else if (wrMem) begin
      dataMem[memIdx] <= pwdata[7:0];
    end else if (doMem) begin
      dataMem[cmd.addr] <= next_mem;
    end
  end

endmodule

/* hdl/cabo_pkg.sv */
// shared constants and types for the complement and bit operation unit
package cabo_pkg;

  // apb register byte offsets
  localparam logic [7:0] CABO_CMD_OFS = 8'h00;
  localparam logic [7:0] CABO_WORK_OFS = 8'h04;
  localparam logic [7:0] CABO_FLAGS_OFS = 8'h08;
  localparam logic [7:0] CABO_PA_DATA_OFS = 8'h0c;
  localparam logic [7:0] CABO_PA_DIR_OFS = 8'h10;
  localparam logic [7:0] CABO_PB_DATA_OFS = 8'h14;
  localparam logic [7:0] CABO_PB_DIR_OFS = 8'h18;
  localparam logic [7:0] CABO_PA_PIN_OFS = 8'h1c;
  localparam logic [7:0] CABO_PB_PIN_OFS = 8'h20;

  // data memory window: bytes at 0x40 + 4 * index
  localparam logic [1:0] CABO_MEM_WIN = 2'h1;
  localparam int CABO_MEM_WIN_MSB = 7;
  localparam int CABO_MEM_WIN_LSB = 6;
  localparam int CABO_MEM_IDX_MSB = 5;
  localparam int CABO_MEM_IDX_LSB = 2;
  localparam int CABO_MEM_DEPTH = 16;

  // command word field positions; cabo_cmd_t puts the bit index at bit 5, bit 4 is spare
  localparam int CABO_CMD_OP_LSB = 0;
  localparam int CABO_CMD_BIT_LSB = 4;
  localparam int CABO_CMD_ADDR_LSB = 8;

  // reset values and the constant one
  localparam logic [7:0] CABO_BYTE_RST = 8'h00;
  localparam logic [7:0] CABO_ONE = 8'h01;
  localparam logic [7:0] CABO_DIR_RST = 8'h00; // all pins inputs

  // selector value in the command address that picks port b
  localparam logic CABO_IO_PORT_B = 1'b1;

  // operation codes of the command register
  typedef enum logic [3:0] {
    CABO_OP_NONE = 4'h0,
    CABO_OP_INVERT_WORK = 4'h1,
    CABO_OP_INVERT_MEM = 4'h2,
    CABO_OP_NEGATE_WORK = 4'h3,
    CABO_OP_NEGATE_MEM = 4'h4,
    CABO_OP_CLEAR_BIT_OP_IO = 4'h5,
    CABO_OP_RAISE_BIT_OP_IO = 4'h6,
    CABO_OP_SWAP_CARRY_IO = 4'h7,
    CABO_OP_CLEAR_BIT_OP_MEM = 4'h8,
    CABO_OP_RAISE_BIT_OP_MEM = 4'h9,
    CABO_OP_ROTATE_RIGHT_CARRY = 4'ha
  } cabo_op_t;

  // command as written by software, packed in register order
  typedef struct packed {
    logic [3:0] addr;
    logic [2:0] bitIdx;
    logic spare;
    logic [3:0] op;
  } cabo_cmd_t;

  // arithmetic flags, bit 0 is zero
  typedef struct packed {
    logic arithSignErrorFlag;
    logic halfCarryFlag;
    logic carryFlag;
    logic zeroFlag;
  } cabo_flags_t;

  localparam cabo_flags_t CABO_FLAGS_RST = 4'h0;

endpackage

/* hdl/cabo_pin_sync.sv */
`timescale 1ns/1ps
// three-stage pin synchroniser with agreement filter
module cabo_pin_sync (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // pins and filtered level
  input wire logic [7:0] pinIn,
  output logic [7:0] pinLevel
);

  logic [7:0] stage1;
  logic [7:0] stage2;
  logic [7:0] stage3;
  logic [7:0] next_pinLevel;

  // a bit takes its new value only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : gBit
      assign next_pinLevel[gi] = (stage2[gi] == stage3[gi]) ?
                                 stage3[gi] : pinLevel[gi];
    end
  endgenerate

  // stage1 feeds only stage2, keeping metastability out of the filter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= 8'h00;
      stage2 <= 8'h00;
      stage3 <= 8'h00;
      pinLevel <= 8'h00;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      pinLevel <= next_pinLevel;
    end
  end

endmodule

/* verif/cabo_core_checker.sv */
`timescale 1ns/1ps
// watches the core ports: apb timing and port latch side effects
module cabo_core_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // ports
  input wire logic [7:0] portAData,
  input wire logic [7:0] portAOe,
  input wire logic [7:0] portBData
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // decode of a completing write and the command it carries
  cabo_pkg::cabo_cmd_t cmd;
  wire done = psel && penable && pready && pwrite;
  wire isCmd = done && paddr == cabo_pkg::CABO_CMD_OFS;
  wire [7:0] selData = cmd.addr[0] ? portBData : portAData;
  wire [7:0] bitMask = 8'h01 << cmd.bitIdx;
  wire [7:0] clrExp = selData & ~bitMask;
  wire [7:0] setExp = selData | bitMask;
  assign cmd = pwdata[11:0];

  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  a_dir_write: assert property (done && paddr == 8'h10 |=>
    portAOe == $past(pwdata[7:0])) else $error("direction not written");
  a_latch_hold: assert property ($changed(portAData) |->
    $past(done && (paddr == 8'h00 || paddr == 8'h0c)))
    else $error("port a latch moved");
  a_clear_port_bit: assert property (isCmd && cmd.op == 4'h5 |=>
    ($past(cmd.addr[0]) ? portBData : portAData) == $past(clrExp))
    else $error("clear port bit wrong");
  a_raise_port_bit: assert property (isCmd && cmd.op == 4'h6 |=>
    ($past(cmd.addr[0]) ? portBData : portAData) == $past(setExp))
    else $error("raise port bit wrong");
endmodule

bind cabo_core cabo_core_checker cabo_core_checker_i (.clock(clock),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .portAData(portAData), .portAOe(portAOe),
  .portBData(portBData));

/* verif/cabo_core_bench.sv */
`timescale 1ns/1ps
// self-checking bench for the complement and bit operation core
module cabo_core_bench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, portAIn = 8'h00, portBIn = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, e;
  logic [7:0] portAData, portAOe, portBData, portBOe;
  int badCount = 0, nTests = 0;

  always #2 clock = ~clock;

  cabo_core cabo_core_i (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .portAIn(portAIn), .portAData(portAData), .portAOe(portAOe),
    .portBIn(portBIn), .portBData(portBData), .portBOe(portBOe));

  task giveVerdict;
    $display("comparisons %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; waits for pready under a bound
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      badCount++;
      giveVerdict;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(r, exp);
  endtask

  // builds and issues a command word
  task op(input logic [3:0] o, input logic [2:0] b, input logic [3:0] a);
    cabo_pkg::cabo_cmd_t c;
    c = '{a, b, 1'b0, o};
    wr(8'h00, {20'h0, c});
  endtask

  task tInvert;
    wr(8'h08, 32'he);
    wr(8'h04, 32'h38);
    op(4'h1, 3'h0, 4'h0);
    rd(8'h04, 32'hc7);
    rd(8'h08, 32'he);
    wr(8'h04, 32'hff);
    op(4'h1, 3'h0, 4'h0);
    rd(8'h08, 32'hf);
  endtask

  task tNegate;
    wr(8'h08, 32'h0);
    wr(8'h04, 32'h38);
    op(4'h3, 3'h0, 4'h0);
    rd(8'h04, 32'hc8);
    rd(8'h08, 32'h0);
    wr(8'h08, 32'he);
    wr(8'h04, 32'h0);
    op(4'h3, 3'h0, 4'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'hf);
  endtask

  task tMem;
    wr(8'h54, 32'h38);
    op(4'h2, 3'h0, 4'h5);
    rd(8'h54, 32'hc7);
    rd(8'h08, 32'he);
    op(4'h4, 3'h0, 4'h5);
    rd(8'h54, 32'h39);
    wr(8'h58, 32'h0);
    op(4'h4, 3'h0, 4'h6);
    rd(8'h08, 32'hf);
  endtask

  // every bit index, on two bytes at the top of memory
  task tMemBits;
    logic [7:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      wr(8'h7c, 32'hff);
      op(4'h8, i[2:0], 4'hf);
      rd(8'h7c, {24'h0, ~m});
      wr(8'h78, 32'h0);
      op(4'h9, i[2:0], 4'he);
      rd(8'h78, {24'h0, m});
    end
    rd(8'h08, 32'hf);
  endtask

  task tPortBits;
    wr(8'h14, 32'h0);
    op(4'h6, 3'h5, 4'h1);
    rd(8'h14, 32'h20);
    wr(8'h0c, 32'hff);
    op(4'h5, 3'h0, 4'h0);
    rd(8'h0c, 32'hfe);
    rd(8'h08, 32'hf);
  endtask

  task tSwapOut;
    wr(8'h10, 32'h1);
    wr(8'h0c, 32'h1);
    wr(8'h08, 32'hd);
    op(4'h7, 3'h0, 4'h0);
    rd(8'h08, 32'hf);
    @(negedge clock);
    check(portAOe, 8'h01);
    check(portAData, 8'h00);
    op(4'h7, 3'h0, 4'h0);
    rd(8'h0c, 32'h1);
    rd(8'h08, 32'hd);
  endtask

  // pin filter needs 4 edges, so wait 6 before sampling
  task tSwapIn;
    wr(8'h10, 32'h0);
    portAIn <= 8'h01;
    repeat (6) @(posedge clock);
    rd(8'h1c, 32'h1);
    wr(8'h08, 32'h0);
    op(4'h7, 3'h0, 4'h0);
    rd(8'h08, 32'h2);
    wr(8'h04, 32'h0);
    op(4'ha, 3'h0, 4'h0);
    rd(8'h04, 32'h80);
    rd(8'h08, 32'h0);
  endtask

  // port b: input bit into carry, then old carry onto an output bit
  task tPortB;
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h80);
    portBIn <= 8'h40;
    repeat (6) @(posedge clock);
    rd(8'h20, 32'h40);
    wr(8'h08, 32'h0);
    op(4'h7, 3'h6, 4'h1);
    rd(8'h08, 32'h2);
    op(4'h7, 3'h7, 4'h1);
    rd(8'h08, 32'h0);
    @(negedge clock);
    check(portBData, 8'h80);
    check(portBOe, 8'h80);
  endtask

  // codes with no operation must leave work register and flags alone
  task tNoOp;
    wr(8'h04, 32'h5a);
    wr(8'h08, 32'h5);
    op(4'h0, 3'h0, 4'h0);
    op(4'hf, 3'h7, 4'h0);
    rd(8'h04, 32'h5a);
    rd(8'h08, 32'h5);
  endtask

  task tRefused;
    xfer(1'b0, 8'h24, 32'h0);
    check(e, 1'b1);
    xfer(1'b1, 8'h1c, 32'h0);
    check(e, 1'b1);
  endtask

  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd(8'h04, 32'h0);
    tInvert;
    tNegate;
    tMem;
    tMemBits;
    tPortBits;
    tSwapOut;
    tSwapIn;
    tPortB;
    tNoOp;
    tRefused;
    giveVerdict;
  end
endmodule
